/* File: hw/pmc_cfg.svh */
// Register offsets, field positions, reset values and counts of the power mode controller
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_ADDR_W 6
`define PMC_OFF_PLL 6'h00
`define PMC_OFF_REG 6'h04
`define PMC_OFF_MODE 6'h08
`define PMC_OFF_PCLK 6'h0C
`define PMC_OFF_STAT 6'h10
`define PMC_PLL_BYPASS 0
`define PMC_PLL_DIS 1
`define PMC_PLL_MSEL_LO 8
`define PMC_MSEL_W 6
`define PMC_MSEL_RST 6'h0A
`define PMC_REG_REGULATOR_FIELD_A_LO 0
`define PMC_REG_REGULATOR_FIELD_A_W 2
`define PMC_REG_REGULATOR_FIELD_A_RST 2'h3
`define PMC_REG_LVL_LO 4
`define PMC_REG_LVL_W 4
`define PMC_REG_LVL_RST 4'h0
`define PMC_REQ_W 3
`define PMC_NPERIPH 16
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2
`endif

/* File: hw/pmc_pkg.sv */
// Types shared by the power mode controller
// Assumes pmc_cfg.svh supplies the numeric constants
package pmc_pkg;
  typedef enum logic [2:0] {
    MODE_FULL_ON = 3'h0,
    MODE_ACTIVE = 3'h1,
    MODE_SLEEP = 3'h2,
    MODE_DEEP_SLEEP = 3'h3,
    MODE_HIBERNATE = 3'h4
  } mode_t;
  typedef enum logic [2:0] {
    REQ_NONE = 3'h0,
    REQ_FULL_ON = 3'h1,
    REQ_ACTIVE = 3'h2,
    REQ_SLEEP = 3'h3,
    REQ_DEEP_SLEEP = 3'h4,
    REQ_HIBERNATE = 3'h5
  } req_t;
  typedef struct packed {
    logic pll_en;
    logic pll_bypass;
    logic core_clk_en;
    logic sys_clk_en;
    logic core_power;
    logic dma_l1_allow;
  } pwr_ctl_t;
endpackage

/* File: hw/power_mode_controller.sv */
// Power mode controller: mode state machine, PLL/clock/power controls, AXI4-Lite registers
// Assumes wakeup and RTC interrupt pins are asynchronous; one clock, synchronous reset
`timescale 1ns/1ns
`include "pmc_cfg.svh"

module power_mode_controller #(
  parameter int NPERIPH = `PMC_NPERIPH
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [`PMC_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`PMC_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Wakeup sources (asynchronous pins)
  input wire logic wakeup_i,
  input wire logic rtc_irq_i,
  // Power and clock controls
  output pmc_pkg::pwr_ctl_t pwr_ctl_o,
  output logic [`PMC_MSEL_W-1:0] pll_msel_o,
  output logic [NPERIPH-1:0] periph_clk_en_o,
  output logic [`PMC_REG_LVL_W-1:0] core_vlevel_o,
  output logic external_wake_out_o,
  output logic hw_reset_req_o
);
  // Synchronisers: change counts once stages two and three agree; flops sit with the bus state
  logic [2:0] wk_sync, rtc_sync;
  logic wk_lvl, rtc_lvl, next_wk_lvl, next_rtc_lvl, wk_rise, rtc_rise;
  assign next_wk_lvl = (wk_sync[1] == wk_sync[2]) ? wk_sync[1] : wk_lvl;
  assign next_rtc_lvl = (rtc_sync[1] == rtc_sync[2]) ? rtc_sync[1] : rtc_lvl;
  assign wk_rise = next_wk_lvl & ~wk_lvl;
  assign rtc_rise = next_rtc_lvl & ~rtc_lvl;

  // Register state, current and next
  logic pll_bypass, pll_dis, ignored, next_pll_bypass, next_pll_dis, next_ignored;
  logic [`PMC_MSEL_W-1:0] msel_pend, msel_act, next_msel_pend, next_msel_act;
  logic [`PMC_REG_REGULATOR_FIELD_A_W-1:0] reg_regulator_field_a, next_reg_regulator_field_a;
  logic [`PMC_REG_LVL_W-1:0] reg_lvl, next_reg_lvl;
  logic [NPERIPH-1:0] pclk_en, next_pclk_en;
  pmc_pkg::req_t req, next_req;
  pmc_pkg::mode_t mode, next_mode;
  // Bus state
  logic aw_held, w_held, bvalid, arready_r, rvalid, do_write, hib_wake;
  logic next_aw_held, next_w_held, next_bvalid, next_arready, next_rvalid;
  logic [`PMC_ADDR_W-1:0] aw_addr, ar_addr, next_aw_addr, next_ar_addr;
  logic [31:0] w_data, rdata, next_w_data, next_rdata;
  logic [1:0] bresp, rresp, next_bresp, next_rresp;

  // Write path: address and data taken in either order, answer after both
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_bvalid = bvalid;
    next_bresp = bresp;
    do_write = 1'b0;
    if (s_axi_awvalid_i && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
    end
    if (bvalid && s_axi_bready_i) next_bvalid = 1'b0;
    if (aw_held && w_held && !bvalid) begin
      do_write = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      unique case (aw_addr)
        `PMC_OFF_PLL, `PMC_OFF_REG, `PMC_OFF_MODE, `PMC_OFF_PCLK: next_bresp = `PMC_RESP_OKAY;
        default: next_bresp = `PMC_RESP_SLVERR;
      endcase
    end
  end

  // Register writes; byte strobes ignored since all fields fit the low lanes
  always_comb begin
    next_pll_bypass = pll_bypass;
    next_pll_dis = pll_dis;
    next_msel_pend = msel_pend;
    next_reg_regulator_field_a = reg_regulator_field_a;
    next_reg_lvl = reg_lvl;
    next_pclk_en = pclk_en;
    next_req = pmc_pkg::REQ_NONE;
    if (do_write) begin
      unique case (aw_addr)
        `PMC_OFF_PLL: begin
          next_pll_bypass = w_data[`PMC_PLL_BYPASS];
          // Disable only honoured in active mode
          next_pll_dis = (mode == pmc_pkg::MODE_ACTIVE) ? w_data[`PMC_PLL_DIS] : 1'b0;
          next_msel_pend = w_data[`PMC_PLL_MSEL_LO +: `PMC_MSEL_W];
        end
        `PMC_OFF_REG: begin
          next_reg_regulator_field_a = w_data[`PMC_REG_REGULATOR_FIELD_A_LO +: `PMC_REG_REGULATOR_FIELD_A_W];
          next_reg_lvl = w_data[`PMC_REG_LVL_LO +: `PMC_REG_LVL_W];
          if (next_reg_regulator_field_a == '0) next_req = pmc_pkg::REQ_HIBERNATE;
        end
        `PMC_OFF_MODE: next_req = pmc_pkg::req_t'(w_data[`PMC_REQ_W-1:0]);
        `PMC_OFF_PCLK: next_pclk_en = w_data[NPERIPH-1:0];
        default: next_req = pmc_pkg::REQ_NONE;
      endcase
    end
  end

  // Mode state machine
  always_comb begin
    next_mode = mode;
    next_msel_act = msel_act;
    next_ignored = ignored;
    hib_wake = 1'b0;
    unique case (mode)
      pmc_pkg::MODE_FULL_ON, pmc_pkg::MODE_ACTIVE: begin
        unique case (req)
          pmc_pkg::REQ_FULL_ON, pmc_pkg::REQ_SLEEP: begin
            if (pll_dis) begin
              next_ignored = 1'b1;
            end else begin
              next_ignored = 1'b0;
              next_mode = (req == pmc_pkg::REQ_FULL_ON) ? pmc_pkg::MODE_FULL_ON
                                                        : pmc_pkg::MODE_SLEEP;
            end
          end
          pmc_pkg::REQ_ACTIVE: next_mode = pmc_pkg::MODE_ACTIVE;
          pmc_pkg::REQ_DEEP_SLEEP: next_mode = pmc_pkg::MODE_DEEP_SLEEP;
          pmc_pkg::REQ_HIBERNATE: next_mode = pmc_pkg::MODE_HIBERNATE;
          default: next_mode = mode;
        endcase
      end
      pmc_pkg::MODE_SLEEP: begin
        // Bypass bit picks the destination
        if (wk_rise) next_mode = pll_bypass ? pmc_pkg::MODE_ACTIVE : pmc_pkg::MODE_FULL_ON;
      end
      pmc_pkg::MODE_DEEP_SLEEP: begin
        if (rtc_rise) next_mode = pmc_pkg::MODE_ACTIVE;
      end
      pmc_pkg::MODE_HIBERNATE: hib_wake = wk_rise | rtc_rise;
      default: next_mode = pmc_pkg::MODE_FULL_ON;
    endcase
    // Multiplier change lands only as full-on is entered
    if (next_mode == pmc_pkg::MODE_FULL_ON && mode != pmc_pkg::MODE_FULL_ON) begin
      next_msel_act = msel_pend;
    end
  end

  // Output decode per mode
  pmc_pkg::pwr_ctl_t next_pwr;
  logic [NPERIPH-1:0] next_pclk_out;
  always_comb begin
    next_pwr = '0;
    next_pclk_out = '0;
    unique case (next_mode)
      pmc_pkg::MODE_FULL_ON: begin
        next_pwr = '{pll_en: 1'b1, pll_bypass: 1'b0, core_clk_en: 1'b1,
                     sys_clk_en: 1'b1, core_power: 1'b1, dma_l1_allow: 1'b1};
        next_pclk_out = next_pclk_en;
      end
      pmc_pkg::MODE_ACTIVE: begin
        // Bypass routes input_clk to both clocks
        next_pwr = '{pll_en: ~next_pll_dis, pll_bypass: 1'b1, core_clk_en: 1'b1,
                     sys_clk_en: 1'b1, core_power: 1'b1, dma_l1_allow: 1'b1};
        next_pclk_out = next_pclk_en;
      end
      pmc_pkg::MODE_SLEEP: begin
        // Core clock off, PLL and system clock on, no DMA
        next_pwr = '{pll_en: 1'b1, pll_bypass: next_pll_bypass, core_clk_en: 1'b0,
                     sys_clk_en: 1'b1, core_power: 1'b1, dma_l1_allow: 1'b0};
        next_pclk_out = next_pclk_en;
      end
      pmc_pkg::MODE_DEEP_SLEEP: next_pwr.core_power = 1'b1;
      pmc_pkg::MODE_HIBERNATE: next_pwr = '0;
      default: next_pwr = '0;
    endcase
  end

  // Read path
  always_comb begin
    next_arready = 1'b0;
    next_ar_addr = ar_addr;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready_i) next_rvalid = 1'b0;
    if (s_axi_arvalid_i && !arready_r && !rvalid) begin
      next_arready = 1'b1;
      next_ar_addr = s_axi_araddr_i;
    end
    if (arready_r) begin
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = `PMC_RESP_OKAY;
      unique case (ar_addr)
        `PMC_OFF_PLL: begin
          next_rdata[`PMC_PLL_BYPASS] = pll_bypass;
          next_rdata[`PMC_PLL_DIS] = pll_dis;
          next_rdata[`PMC_PLL_MSEL_LO +: `PMC_MSEL_W] = msel_pend;
        end
        `PMC_OFF_REG: begin
          next_rdata[`PMC_REG_REGULATOR_FIELD_A_LO +: `PMC_REG_REGULATOR_FIELD_A_W] = reg_regulator_field_a;
          next_rdata[`PMC_REG_LVL_LO +: `PMC_REG_LVL_W] = reg_lvl;
        end
        `PMC_OFF_MODE: next_rdata[`PMC_REQ_W-1:0] = 3'h0;
        `PMC_OFF_PCLK: next_rdata[NPERIPH-1:0] = pclk_en;
        // Mode, ignored-request flag and active multiplier
        `PMC_OFF_STAT: next_rdata = {16'h0000, 2'h0, msel_act, 4'h0, ignored, mode};
        default: next_rresp = `PMC_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    // Hibernate wakeup acts as hardware reset back to full-on
    if (rst_i || hw_reset_req_o) begin
      mode <= pmc_pkg::MODE_FULL_ON;
      pll_bypass <= 1'b0;
      pll_dis <= 1'b0;
      msel_pend <= `PMC_MSEL_RST;
      msel_act <= `PMC_MSEL_RST;
      pclk_en <= '1;
      req <= pmc_pkg::REQ_NONE;
      ignored <= 1'b0;
      pwr_ctl_o <= '{pll_en: 1'b1, pll_bypass: 1'b0, core_clk_en: 1'b1,
                     sys_clk_en: 1'b1, core_power: 1'b1, dma_l1_allow: 1'b1};
      pll_msel_o <= `PMC_MSEL_RST;
      periph_clk_en_o <= '1;
    end else begin
      mode <= next_mode;
      pll_bypass <= next_pll_bypass;
      pll_dis <= next_pll_dis;
      msel_pend <= next_msel_pend;
      msel_act <= next_msel_act;
      pclk_en <= next_pclk_en;
      req <= next_req;
      ignored <= next_ignored;
      pwr_ctl_o <= next_pwr;
      pll_msel_o <= next_msel_act;
      periph_clk_en_o <= next_pclk_out;
    end
  end

  // Regulator level survives hibernate, field A reloads on wakeup; bus logic resets only on rst_i
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_regulator_field_a <= `PMC_REG_REGULATOR_FIELD_A_RST;
      reg_lvl <= `PMC_REG_LVL_RST;
      core_vlevel_o <= `PMC_REG_LVL_RST;
      external_wake_out_o <= 1'b1;
      hw_reset_req_o <= 1'b0;
      wk_sync <= 3'h0;
      rtc_sync <= 3'h0;
      wk_lvl <= 1'b0;
      rtc_lvl <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      bvalid <= 1'b0;
      bresp <= `PMC_RESP_OKAY;
      arready_r <= 1'b0;
      ar_addr <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `PMC_RESP_OKAY;
    end else begin
      // Wakeup in hibernate raises wake again so the regulator powers up
      reg_regulator_field_a <= hib_wake ? `PMC_REG_REGULATOR_FIELD_A_RST : next_reg_regulator_field_a;
      reg_lvl <= next_reg_lvl;
      core_vlevel_o <= next_reg_lvl;
      external_wake_out_o <= hib_wake | (next_reg_regulator_field_a != '0);
      hw_reset_req_o <= hib_wake;
      wk_sync <= {wk_sync[1:0], wakeup_i};
      rtc_sync <= {rtc_sync[1:0], rtc_irq_i};
      wk_lvl <= next_wk_lvl;
      rtc_lvl <= next_rtc_lvl;
      // Ready outputs come from their own flops, each the inverse of its held flag
      s_axi_awready_o <= ~next_aw_held;
      s_axi_wready_o <= ~next_w_held;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready_r <= next_arready;
      ar_addr <= next_ar_addr;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;
endmodule

/* File: tb/pmc_chk.sv */
// Checker for the mode outputs of the power mode controller
// Assumes binding to power_mode_controller; it sees only that module's ports
`timescale 1ns/1ns
module pmc_chk #(
  parameter int NPERIPH = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic wakeup_i,
  input wire logic rtc_irq_i,
  input wire pmc_pkg::pwr_ctl_t pwr_ctl_o,
  input wire logic [NPERIPH-1:0] periph_clk_en_o,
  input wire logic external_wake_out_o,
  input wire logic hw_reset_req_o
);
  pmc_pkg::pwr_ctl_t p;
  assign p = pwr_ctl_o;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  rst_full_a: assert property ($fell(rst_i) |-> p == 6'h2f && external_wake_out_o)
    else $error("not full-on after reset");
  full_on_a: assert property (!p.pll_bypass && p.core_clk_en |-> p.pll_en && p.sys_clk_en)
    else $error("full-on mix wrong");
  active_a: assert property (p.pll_bypass && p.core_clk_en |-> p.sys_clk_en && p.dma_l1_allow)
    else $error("active mix wrong");
  sleep_a: assert property (p.sys_clk_en && !p.core_clk_en |-> p.pll_en && !p.dma_l1_allow)
    else $error("sleep mix wrong");
  deep_a: assert property (p.core_power && !p.sys_clk_en |-> !p.pll_en && periph_clk_en_o == '0)
    else $error("deep sleep mix wrong");
  hib_off_a: assert property (!p.core_power |-> !(p.pll_en || p.core_clk_en || p.sys_clk_en))
    else $error("hibernate mix wrong");
  wake_low_a: assert property ($fell(external_wake_out_o) |-> ##[0:4] !p.core_power)
    else $error("regulator off without hibernate");
  hib_reset_a: assert property (hw_reset_req_o |-> !p.core_power ##[1:3] p == 6'h2f)
    else $error("hibernate wake not reset to full-on");
  sleep_wake_a: assert property (p.sys_clk_en && !p.core_clk_en && $rose(wakeup_i)
    |-> ##[1:8] p.core_clk_en)
    else $error("no wake from sleep");
  rtc_wake_a: assert property (p.core_power && !p.sys_clk_en && $rose(rtc_irq_i)
    |-> ##[1:8] p.pll_bypass && p.core_clk_en)
    else $error("no rtc wake to active");
  cover property (p.sys_clk_en && !p.core_clk_en);
  cover property (p.core_power && !p.sys_clk_en);
  cover property (hw_reset_req_o);
endmodule

bind power_mode_controller pmc_chk #(.NPERIPH(NPERIPH)) u_chk (.mclk_i, .rst_i, .wakeup_i,
  .rtc_irq_i, .pwr_ctl_o, .periph_clk_en_o, .external_wake_out_o, .hw_reset_req_o);

/* File: tb/pmc_far_model.sv */
// Wakeup sources and external core regulator beside the power mode controller
// Assumes one-cycle kick strobes from the bench, set on the rising clock edge
`timescale 1ns/1ns
module pmc_far_model (
  // Clock
  input wire logic mclk_i,
  // Strobes and regulator enable
  input wire logic kick_wake_i,
  input wire logic kick_rtc_i,
  input wire logic external_wake_out_i,
  // Wake pins and supply state
  output logic wakeup_o,
  output logic rtc_irq_o,
  output logic vdd_up_o
);
  logic [2:0] wcnt = 3'h0;
  logic [2:0] rcnt = 3'h0;
  logic [1:0] ramp = 2'h3;
  // Pins stay high four cycles so a three-flop synchroniser cannot miss them
  always @(posedge mclk_i) begin
    wcnt <= kick_wake_i ? 3'h4 : (wcnt != 3'h0 ? wcnt - 3'h1 : 3'h0);
    rcnt <= kick_rtc_i ? 3'h4 : (rcnt != 3'h0 ? rcnt - 3'h1 : 3'h0);
    // Supply drops at once but needs a few cycles to ramp back
    ramp <= !external_wake_out_i ? 2'h0 : (ramp != 2'h3 ? ramp + 2'h1 : ramp);
  end
  assign wakeup_o = wcnt != 3'h0;
  assign rtc_irq_o = rcnt != 3'h0;
  assign vdd_up_o = ramp == 2'h3;
endmodule

/* File: tb/power_mode_controller_tb_top.sv */
// Self-checking bench for the power mode controller over AXI4-Lite
// Assumes pmc_far_model drives the wake pins; reads are judged by a monitor
`timescale 1ns/1ns
`include "pmc_cfg.svh"
module power_mode_controller_tb_top;
  localparam logic [39:0] ALL = 40'hff_ffff_ffff;
  localparam logic [1:0] OK = `PMC_RESP_OKAY;
  localparam logic [1:0] SE = `PMC_RESP_SLVERR;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic kick_wake = 1'b0, kick_rtc = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wakeup, rtc, external_wake_out, hw_rst, vdd_up;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, r;
  pmc_pkg::pwr_ctl_t pwr;
  logic [5:0] msel;
  logic [15:0] pclk;
  logic [3:0] vlvl;
  logic [79:0] e;
  logic [79:0] q[$];
  logic [1:0] bq[$];
  int miscompares = 0, n_compared = 0, seed = 28652, pulses = 0;

  always #50 mclk_i = ~mclk_i;

  power_mode_controller u_dut (.mclk_i, .rst_i, .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .wakeup_i(wakeup), .rtc_irq_i(rtc), .pwr_ctl_o(pwr),
    .pll_msel_o(msel), .periph_clk_en_o(pclk), .core_vlevel_o(vlvl),
    .external_wake_out_o(external_wake_out), .hw_reset_req_o(hw_rst));

  pmc_far_model u_far (.mclk_i, .kick_wake_i(kick_wake), .kick_rtc_i(kick_rtc),
    .external_wake_out_i(external_wake_out), .wakeup_o(wakeup), .rtc_irq_o(rtc), .vdd_up_o(vdd_up));

  task automatic cmp(input logic [39:0] a, input logic [39:0] x, input logic [39:0] m);
    n_compared++;
    if ((a & m) !== (x & m)) begin
      miscompares++;
      $display("BAD t=%0t got %h want %h", $time, a & m, x & m);
    end
  endtask

  // Results are judged where they leave the bus, oldest note first
  always @(posedge mclk_i) begin
    if (hw_rst === 1'b1) pulses++;
    if (rvalid && rready) begin
      e = q.pop_front();
      cmp({rresp, rdata, pwr}, e[39:0], e[79:40]);
    end
    if (bvalid && bready) cmp(40'(bresp), 40'(bq.pop_front()), ALL);
  end

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] rs);
    bit ad = 1'b0;
    bit wd = 1'b0;
    @(posedge mclk_i);
    bq.push_back(rs);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk_i);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge mclk_i);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [39:0] x, input logic [39:0] m);
    @(posedge mclk_i);
    q.push_back({m, x});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge mclk_i);
    while (!arready) @(posedge mclk_i);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge mclk_i);
    rready <= 1'b0;
  endtask

  // Status read; the ignored-request flag is left out unless a test reads it whole
  task automatic st(input logic [2:0] md, input logic [5:0] ms, input logic [5:0] pv,
    input logic [5:0] pm);
    rd(`PMC_OFF_STAT, {2'h0, 18'h0_0000, ms, 5'h00, md, pv}, {34'h3_ffff_fff7, pm});
  endtask

  task automatic kick(input bit use_rtc);
    @(posedge mclk_i);
    kick_wake <= !use_rtc;
    kick_rtc <= use_rtc;
    @(posedge mclk_i);
    kick_wake <= 1'b0;
    kick_rtc <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    st(3'h0, 6'h0a, 6'h2f, 6'h3f);
    @(negedge mclk_i);
    cmp(40'({msel, pclk, vlvl, external_wake_out}), 40'({6'h0a, 16'hffff, 4'h0, 1'b1}), ALL);
    $display("test reset done");
    wr(`PMC_OFF_MODE, 32'h0000_0002, OK);
    st(3'h1, 6'h0a, 6'h3f, 6'h3f);
    wr(`PMC_OFF_PLL, 32'h0000_1503, OK);
    st(3'h1, 6'h0a, 6'h1f, 6'h3f);
    cmp(40'(msel), 40'h00_0000_000a, ALL);
    for (int m = 1; m <= 3; m += 2) begin
      wr(`PMC_OFF_MODE, 32'(m), OK);
      rd(`PMC_OFF_STAT, {2'h0, 32'h0000_0a09, 6'h1f}, ALL);
    end
    wr(`PMC_OFF_PLL, 32'h0000_1501, OK);
    wr(`PMC_OFF_MODE, 32'h0000_0001, OK);
    st(3'h0, 6'h15, 6'h2f, 6'h3f);
    cmp(40'(msel), 40'h00_0000_0015, ALL);
    $display("test active done");
    for (int b = 0; b < 2; b++) begin
      wr(`PMC_OFF_PLL, 32'h0000_1500 | 32'(b), OK);
      wr(`PMC_OFF_MODE, 32'h0000_0003, OK);
      st(3'h2, 6'h15, 6'h26, 6'h2f);
      kick(1'b0);
      st(3'(b), 6'h15, b ? 6'h3f : 6'h2f, 6'h3f);
    end
    $display("test sleep done");
    r = $random(seed);
    wr(`PMC_OFF_PCLK, {16'h0000, r[15:0]}, OK);
    @(negedge mclk_i);
    cmp(40'(pclk), 40'(r[15:0]), ALL);
    rd(`PMC_OFF_PCLK, {2'h0, 16'h0000, r[15:0], 6'h3f}, ALL);
    wr(`PMC_OFF_MODE, 32'h0000_0004, OK);
    st(3'h3, 6'h15, 6'h02, 6'h2e);
    @(negedge mclk_i);
    cmp(40'(pclk), 40'h00_0000_0000, ALL);
    kick(1'b1);
    st(3'h1, 6'h15, 6'h3f, 6'h3f);
    $display("test deep sleep done");
    r = $random(seed);
    wr(`PMC_OFF_REG, {24'h00_0000, r[3:0], 4'h3}, OK);
    @(negedge mclk_i);
    cmp(40'(vlvl), 40'(r[3:0]), ALL);
    wr(`PMC_OFF_REG, {24'h00_0000, r[3:0], 4'h0}, OK);
    st(3'h4, 6'h15, 6'h00, 6'h2e);
    @(negedge mclk_i);
    cmp(40'({external_wake_out, vdd_up}), 40'h00_0000_0000, ALL);
    kick(1'b0);
    cmp(40'(pulses), 40'h00_0000_0001, ALL);
    st(3'h0, 6'h0a, 6'h2f, 6'h3f);
    rd(`PMC_OFF_REG, {2'h0, 24'h00_0000, r[3:0], 4'h3, 6'h2f}, ALL);
    $display("test hibernate done");
    // Reset in deep sleep, then hibernate by mode code and leave it by the RTC pin
    wr(`PMC_OFF_MODE, 32'h0000_0004, OK);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    st(3'h0, 6'h0a, 6'h2f, 6'h3f);
    wr(`PMC_OFF_MODE, 32'h0000_0005, OK);
    st(3'h4, 6'h0a, 6'h00, 6'h2e);
    kick(1'b1);
    cmp(40'(pulses), 40'h00_0000_0002, ALL);
    st(3'h0, 6'h0a, 6'h2f, 6'h3f);
    $display("test reset exit done");
    wr(6'h14, 32'h0000_0001, SE);
    rd(6'h14, {2'h2, 32'h0000_0000, 6'h2f}, ALL);
    wr(`PMC_OFF_STAT, 32'h0000_0000, SE);
    rd(`PMC_OFF_MODE, {2'h0, 32'h0000_0000, 6'h2f}, ALL);
    $display("test bus errors done");
    end_of_test;
  end

  // The full sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge mclk_i);
    miscompares++;
    end_of_test;
  end
endmodule
